/* home_search_pkg.sv */
package home_search_pkg;

    // apb register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_DATA_LOW = 8'h04;
    localparam logic [7:0] OFS_INPUT_CFG = 8'h08;
    localparam logic [7:0] OFS_MAIN_STATUS = 8'h0C;
    localparam logic [7:0] OFS_AXIS_ERROR = 8'h10;
    localparam logic [7:0] OFS_AXIS_STOP = 8'h14;
    localparam logic [7:0] OFS_MODE = 8'h18;
    localparam logic [7:0] OFS_SPEED = 8'h1C;

    // command codes, axis select bit included
    localparam logic [15:0] CMD_LOAD_MODE = 16'h0160;
    localparam logic [15:0] CMD_LOAD_SPEED = 16'h0161;
    localparam logic [15:0] CMD_START = 16'h0162;
    localparam logic [15:0] CMD_CLR_STATUS = 16'h0125;
    localparam logic [15:0] CMD_DEC_STOP = 16'h0126;
    localparam logic [15:0] CMD_INST_STOP = 16'h0127;

    // search mode word fields
    localparam int MODE_CLR_CNT = 8;
    localparam int MODE_Z_AND_HOME = 9;
    localparam int MODE_LIMIT_HOME = 10;
    localparam int MODE_DCC_EN = 11;
    localparam int MODE_DCC_LOW = 12;
    localparam int MODE_DCC_W_LSB = 13;
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // input configuration level bits, 1 = active high
    localparam int CFG_NEAR_LVL = 2;
    localparam int CFG_HOME_LVL = 4;
    localparam int CFG_Z_LVL = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // status bit positions
    localparam int MS_DRIVE = 0;
    localparam int MS_ERROR = 4;
    localparam int MS_RUNNING = 8;
    localparam int ES_LIM_NEG = 2;
    localparam int ES_LIM_POS = 3;
    localparam int ES_Z_ACTIVE = 7;
    localparam int SS_LIM_NEG = 0;
    localparam int SS_LIM_POS = 1;

    // execution state codes
    localparam logic [4:0] EXEC_IDLE = 5'h00;
    localparam logic [4:0] EXEC_S1 = 5'h03;
    localparam logic [4:0] EXEC_S2_REV = 5'h08;
    localparam logic [4:0] EXEC_S2_ESC = 5'h0C;
    localparam logic [4:0] EXEC_S2 = 5'h0F;
    localparam logic [4:0] EXEC_S3 = 5'h14;
    localparam logic [4:0] EXEC_S4 = 5'h19;

    // clearing pulse timing
    localparam int CLK_MHZ = 100;
    localparam int DCC_UNIT_US = 10;
    localparam int DCC_UNIT_CYCLES = DCC_UNIT_US * CLK_MHZ;
    localparam int DCC_MULT [8] = '{1, 2, 10, 20, 100, 200, 1000, 2000};

    typedef enum logic [10:0] {
        ST_IDLE = 11'b000_0000_0001,
        ST_S1 = 11'b000_0000_0010,
        ST_S2_CHK = 11'b000_0000_0100,
        ST_S2_ESC = 11'b000_0000_1000,
        ST_S2 = 11'b000_0001_0000,
        ST_S2_REV = 11'b000_0010_0000,
        ST_S3_CHK = 11'b000_0100_0000,
        ST_S3 = 11'b000_1000_0000,
        ST_DCC = 11'b001_0000_0000,
        ST_S4 = 11'b010_0000_0000,
        ST_DONE = 11'b100_0000_0000
    } step_t;

endpackage

/* home_search_sequencer.sv */
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - held limit blocks motion, flags error unless step1 moves on or step2 reverses
// - no limit and no home means search never ends
// - near home active at start skips step1
// - step1 limit continues into the next enabled step
// - home active at step2: escape opposite
// - step2 limit reverses; opposite limit errors
// - z active at step3 start errors
// - step3 forward limit ends with error
// - step3 stops on z rising edge
// - level bits apply, enable bits ignored
// - levels from config bits 2,4,7
// - clearing pulse at z, coded width/level
// - clear counters after step4 if enabled
// - mode bits 0-7 step enables/directions
// - mode bits 8-11 special options
// - commands load mode, speed, start
// - running bit high during search
// - error bit and causes after abnormal end
// - z error bit cleared by start/25h
// - stop commands terminate the search
module home_search_sequencer
    import home_search_pkg::*;
#(
    parameter int unsigned dcc_unit_cycles = home_search_pkg::DCC_UNIT_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [home_search_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic near_home_input,
    input wire logic home_input,
    input wire logic z_phase_input,
    input wire logic limit_pos_input,
    input wire logic limit_neg_input,
    input wire logic offset_done,
    output logic drive_run,
    output logic drive_dir_neg,
    output logic drive_low_speed,
    output logic drive_offset,
    output logic [15:0] home_search_speed,
    output logic shared_clear_output_pin,
    output logic clear_counters
);
    import home_search_pkg::*;

    if (dcc_unit_cycles < 1 || dcc_unit_cycles > 2000000)
    begin : g_bad_unit
        $error("dcc_unit_cycles out of range");
    end

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic z_prev;
        step_t st;
        logic [15:0] mode;
        logic [15:0] speed;
        logic [15:0] data;
        logic [7:0] incfg;
        logic [7:0] err2;
        logic [1:0] stop1;
        logic [31:0] dcc_cnt;
        logic dcc_act;
        logic clr_pulse;
        logic run;
        logic dir_neg;
        logic low_spd;
        logic offs;
        logic [31:0] prdata;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    ////////////////////////////////////////////////////////////////////////////
    // decoded inputs

    logic near_act, home_act, z_act, lim_pos, lim_neg, z_edge;
    logic wr_acc, cmd_wr, cmd_start, cmd_stop, cmd_clr, addr_ok;
    logic [4:0] exec_code;

    // only the second synchroniser stage is read
    assign near_act = r_q.sync2[0] == r_q.incfg[CFG_NEAR_LVL];
    assign z_act = r_q.sync2[2] == r_q.incfg[CFG_Z_LVL];
    assign lim_pos = r_q.sync2[3];
    assign lim_neg = r_q.sync2[4];
    // limit as home takes the limit lying in the step2 direction
    assign home_act = r_q.mode[MODE_LIMIT_HOME] ? (r_q.mode[3] ? lim_neg : lim_pos)
        : (r_q.sync2[1] == r_q.incfg[CFG_HOME_LVL]);
    assign z_edge = z_act && !r_q.z_prev;

    assign wr_acc = psel && penable && pwrite;
    assign cmd_wr = wr_acc && paddr == OFS_COMMAND;
    assign cmd_start = cmd_wr && pwdata[15:0] == CMD_START;
    assign cmd_stop = cmd_wr && (pwdata[15:0] == CMD_DEC_STOP
        || pwdata[15:0] == CMD_INST_STOP);
    assign cmd_clr = cmd_wr && (pwdata[15:0] == CMD_CLR_STATUS || pwdata[15:0] == CMD_START);
    assign addr_ok = paddr[1:0] == 2'b00 && paddr <= OFS_SPEED;

    always_comb
    begin
        unique case (r_q.st)
            ST_IDLE: exec_code = EXEC_IDLE;
            ST_S1: exec_code = EXEC_S1;
            ST_S2_REV: exec_code = EXEC_S2_REV;
            ST_S2_ESC: exec_code = EXEC_S2_ESC;
            ST_S2_CHK, ST_S2: exec_code = EXEC_S2;
            ST_S3_CHK, ST_S3, ST_DCC: exec_code = EXEC_S3;
            default: exec_code = EXEC_S4;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    function automatic logic lim_dir(input logic neg, input logic lp, input logic ln);
        lim_dir = neg ? ln : lp;
    endfunction

    always_comb
    begin
        step_t after1, after2, after3;
        logic [7:0] eset;
        logic [1:0] sset;
        logic move;
        r_d = r_q;
        eset = 8'h00;
        sset = 2'b00;
        r_d.sync1 = {limit_neg_input, limit_pos_input, z_phase_input, home_input,
            near_home_input};
        r_d.sync2 = r_q.sync1;
        r_d.z_prev = z_act;
        r_d.clr_pulse = 1'b0;
        // enabled steps only, in order
        after3 = r_q.mode[6] ? ST_S4 : ST_DONE;
        after2 = r_q.mode[4] ? ST_S3_CHK : after3;
        after1 = r_q.mode[2] ? ST_S2_CHK : after2;

        unique case (r_q.st)
            ST_IDLE:
            begin
                if (cmd_start)
                begin
                    if (r_q.mode[0] && !near_act)
                        r_d.st = ST_S1;
                    else
                        r_d.st = r_q.mode[0] ? ST_S2_CHK : after1;
                end
            end
            ST_S1:
            begin
                if (lim_dir(r_q.mode[1], lim_pos, lim_neg))
                    r_d.st = after1;
                else if (near_act)
                    r_d.st = after1;
            end
            ST_S2_CHK:
                r_d.st = home_act ? ST_S2_ESC : ST_S2;
            ST_S2_REV:
            begin
                if (lim_dir(!r_q.mode[3], lim_pos, lim_neg))
                    r_d.st = ST_DONE;
                else if (home_act)
                    r_d.st = ST_S2_ESC;
            end
            ST_S2_ESC:
            begin
                if (lim_dir(!r_q.mode[3], lim_pos, lim_neg))
                    r_d.st = ST_DONE;
                else if (!home_act)
                    r_d.st = ST_S2;
            end
            ST_S2:
            begin
                if (home_act)
                    r_d.st = after2;
                else if (lim_dir(r_q.mode[3], lim_pos, lim_neg))
                    r_d.st = ST_S2_REV;
            end
            ST_S3_CHK:
            begin
                if (z_act)
                begin
                    r_d.st = ST_IDLE;
                    eset[ES_Z_ACTIVE] = 1'b1;
                end
                else
                    r_d.st = ST_S3;
            end
            ST_S3:
            begin
                if (lim_dir(r_q.mode[5], lim_pos, lim_neg))
                    r_d.st = ST_DONE;
                else if (z_edge && (!r_q.mode[MODE_Z_AND_HOME] || home_act))
                begin
                    if (r_q.mode[MODE_DCC_EN])
                    begin
                        r_d.st = ST_DCC;
                        r_d.dcc_act = 1'b1;
                        r_d.dcc_cnt = 32'(dcc_unit_cycles
                            * DCC_MULT[r_q.mode[MODE_DCC_W_LSB +: 3]]);
                    end
                    else
                        r_d.st = after3;
                end
            end
            ST_DCC:
            begin
                // axis stands still while the pulse is out
                if (r_q.dcc_cnt <= 32'h0000_0001)
                begin
                    r_d.dcc_act = 1'b0;
                    r_d.st = after3;
                end
                r_d.dcc_cnt = r_q.dcc_cnt - 32'h0000_0001;
            end
            ST_S4:
            begin
                if (lim_dir(r_q.mode[7], lim_pos, lim_neg))
                    r_d.st = ST_DONE;
                else if (offset_done)
                    r_d.st = ST_DONE;
            end
            ST_DONE:
            begin
                r_d.st = ST_IDLE;
                // counters cleared only after a clean finish
                r_d.clr_pulse = r_q.mode[MODE_CLR_CNT] && !lim_pos && !lim_neg;
            end
            default: r_d.st = ST_IDLE;
        endcase

        // a limit reached on the way out is reported at termination
        if (r_d.st == ST_DONE && (r_q.st == ST_S2_ESC || r_q.st == ST_S2_REV))
        begin
            r_d.st = ST_IDLE;
        end
        if (r_q.st != ST_IDLE && r_q.st != ST_DONE && r_q.st != ST_S1 && r_q.st != ST_S2
            && r_q.st != ST_S2_CHK && r_q.st != ST_DCC && r_q.st != ST_S3_CHK
            && (r_d.st == ST_DONE || r_d.st == ST_IDLE) && (lim_pos || lim_neg))
        begin
            eset[ES_LIM_POS] = lim_pos;
            eset[ES_LIM_NEG] = lim_neg;
            sset = {lim_pos, lim_neg};
            r_d.st = ST_IDLE;
        end

        if (cmd_stop && r_q.st != ST_IDLE)
        begin
            r_d.st = ST_IDLE;
            r_d.dcc_act = 1'b0;
            r_d.clr_pulse = 1'b0;
            eset = 8'h00;
            sset = 2'b00;
        end

        // set wins over clear
        r_d.err2 = (r_q.err2 & {8{!cmd_clr}}) | eset;
        r_d.stop1 = (r_q.stop1 & {2{!cmd_clr}}) | sset;

        // drive outputs; a held limit never lets the axis move into it
        unique case (r_d.st)
            ST_S1: r_d.dir_neg = r_q.mode[1];
            ST_S2, ST_S2_CHK: r_d.dir_neg = r_q.mode[3];
            ST_S2_ESC, ST_S2_REV: r_d.dir_neg = !r_q.mode[3];
            ST_S3, ST_S3_CHK, ST_DCC: r_d.dir_neg = r_q.mode[5];
            ST_S4: r_d.dir_neg = r_q.mode[7];
            default: r_d.dir_neg = r_q.dir_neg;
        endcase
        move = r_d.st == ST_S1 || r_d.st == ST_S2 || r_d.st == ST_S2_ESC
            || r_d.st == ST_S2_REV || r_d.st == ST_S3 || r_d.st == ST_S4;
        r_d.run = move && !lim_dir(r_d.dir_neg, lim_pos, lim_neg);
        r_d.low_spd = r_d.st != ST_S1 && r_d.st != ST_S4;
        r_d.offs = r_d.st == ST_S4;

        // register writes
        if (wr_acc)
        begin
            if (paddr == OFS_DATA_LOW)
                r_d.data = pwdata[15:0];
            if (paddr == OFS_INPUT_CFG)
                r_d.incfg = pwdata[7:0];
        end
        if (cmd_wr && pwdata[15:0] == CMD_LOAD_MODE)
            r_d.mode = r_q.data;
        if (cmd_wr && pwdata[15:0] == CMD_LOAD_SPEED)
            r_d.speed = r_q.data;

        // read data captured in the setup phase
        if (psel && !penable)
        begin
            unique case (paddr)
                OFS_DATA_LOW: r_d.prdata = {16'h0000, r_q.data};
                OFS_INPUT_CFG: r_d.prdata = {24'h00_0000, r_q.incfg};
                OFS_MAIN_STATUS: r_d.prdata = {23'h00_0000, r_q.st != ST_IDLE, 3'b000,
                    |r_q.err2 || |r_q.stop1, 3'b000, r_q.run};
                OFS_AXIS_ERROR: r_d.prdata = {19'h0_0000, exec_code, r_q.err2};
                OFS_AXIS_STOP: r_d.prdata = {16'h0000, 2'b00, r_q.stop1, 12'h000};
                OFS_MODE: r_d.prdata = {16'h0000, r_q.mode};
                OFS_SPEED: r_d.prdata = {16'h0000, r_q.speed};
                default: r_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q <= '{sync1: 5'h00, sync2: 5'h00, z_prev: 1'b0, st: ST_IDLE,
                mode: MODE_RESET, speed: 16'h0000, data: 16'h0000, incfg: CFG_RESET,
                err2: 8'h00, stop1: 2'b00, dcc_cnt: 32'h0000_0000, dcc_act: 1'b0,
                clr_pulse: 1'b0, run: 1'b0, dir_neg: 1'b0, low_spd: 1'b0, offs: 1'b0,
                prdata: 32'h0000_0000};
        end
        else if (ce)
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = r_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign drive_run = r_q.run;
    assign drive_dir_neg = r_q.dir_neg;
    assign drive_low_speed = r_q.low_spd;
    assign drive_offset = r_q.offs;
    assign home_search_speed = r_q.speed;
    assign shared_clear_output_pin = r_q.dcc_act ^ r_q.mode[MODE_DCC_LOW];
    assign clear_counters = r_q.clr_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_sets_busy_a: assert property (
        ce && r_q.st == ST_IDLE && cmd_start |=> r_q.st != ST_IDLE)
        else $error("start did not raise running");
    near_skip_a: assert property (
        ce && r_q.st == ST_IDLE && cmd_start && r_q.mode[0] && near_act
        |=> r_q.st == ST_S2_CHK)
        else $error("step1 not skipped with near home active");
    z_start_err_a: assert property (
        ce && r_q.st == ST_S3_CHK && z_act && !cmd_stop
        |=> r_q.err2[ES_Z_ACTIVE] && r_q.st == ST_IDLE)
        else $error("z active at step3 start not flagged");
    z_level_hold_a: assert property (
        ce && r_q.st == ST_S3 && z_act && r_q.z_prev && !cmd_stop && !lim_pos && !lim_neg
        |=> r_q.st == ST_S3)
        else $error("steady z level ended step3");
    step3_limit_a: assert property (
        ce && r_q.st == ST_S3 && lim_dir(r_q.mode[5], lim_pos, lim_neg) && !cmd_stop
        |=> r_q.st == ST_IDLE && (r_q.err2[ES_LIM_POS] || r_q.err2[ES_LIM_NEG]))
        else $error("step3 limit not reported");
    stop_cmd_a: assert property (
        ce && cmd_stop |=> r_q.st == ST_IDLE)
        else $error("stop command did not end search");
    limit_block_a: assert property (
        $past(ce) && drive_run |-> !(drive_dir_neg ? $past(lim_neg) : $past(lim_pos)))
        else $error("axis driven into active limit");
    dcc_pulse_a: assert property (
        ce && r_q.st == ST_S3 && z_edge && r_q.mode[MODE_DCC_EN] && !r_q.mode[MODE_Z_AND_HOME]
        && !cmd_stop && !lim_pos && !lim_neg |=> r_q.dcc_act && r_q.st == ST_DCC)
        else $error("clearing pulse missing at z edge");
    clear_ctr_a: assert property (
        ce && r_q.st == ST_DONE && r_q.mode[MODE_CLR_CNT] && !cmd_stop && !lim_pos && !lim_neg
        |=> clear_counters ##1 !clear_counters)
        else $error("counters not cleared after step4");
    err_clear_a: assert property (
        ce && cmd_clr && r_q.st == ST_IDLE |=> r_q.err2 == 8'h00)
        else $error("error bits not cleared");

    full_search_c: cover property (r_q.st == ST_S1 ##[1:200] r_q.st == ST_S4);
    escape_c: cover property (r_q.st == ST_S2_REV ##[1:200] r_q.st == ST_S2);
    z_error_c: cover property (r_q.st == ST_S3_CHK ##1 r_q.err2[ES_Z_ACTIVE]);
    dcc_c: cover property (r_q.st == ST_DCC ##1 r_q.st == ST_S4);

endmodule

`default_nettype wire

/* sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_model
#(
    parameter int offset_len = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic drive_run,
    input wire logic drive_dir_neg,
    input wire logic drive_offset,
    input wire logic [7:0] cfg,
    input wire logic [4:0] stuck_on,
    input wire logic [4:0] stuck_off,
    input wire logic load,
    input wire logic signed [15:0] start_pos,
    output var logic signed [15:0] pos,
    output logic near_home_input,
    output logic home_input,
    output logic z_phase_input,
    output logic limit_pos_input,
    output logic limit_neg_input,
    output var logic offset_done
);
    logic [4:0] raw;
    logic [4:0] act;
    logic [7:0] ofs_cnt;
    ////////////////////////////////////////
    // sensor map by position; a stuck sensor ignores the axis
    always_comb
    begin
        raw[0] = pos >= 50 && pos <= 100;
        raw[1] = pos >= 60 && pos <= 75;
        // z stays on four steps, longer than the input sync delay
        raw[2] = pos >= 0 && pos[4:2] == 3'b100;
        raw[3] = pos >= 200;
        raw[4] = pos <= -200;
    end
    assign act = (raw | stuck_on) & ~stuck_off;
    assign near_home_input = act[0] ~^ cfg[2];
    assign home_input = act[1] ~^ cfg[4];
    assign z_phase_input = act[2] ~^ cfg[7];
    assign limit_pos_input = act[3];
    assign limit_neg_input = act[4];
    ////////////////////////////////////////
    // one step per cycle while driven
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos <= 16'sh0000;
            ofs_cnt <= 8'h00;
            offset_done <= 1'b0;
        end
        else
        begin
            if (load)
                pos <= start_pos;
            else if (drive_run)
                pos <= drive_dir_neg ? pos - 16'sh0001 : pos + 16'sh0001;
            ofs_cnt <= (drive_offset && drive_run) ? ofs_cnt + 8'h01 : 8'h00;
            offset_done <= drive_offset && drive_run && ofs_cnt == 8'(offset_len - 1);
        end
    end
endmodule
`default_nettype wire

/* home_search_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module home_search_sequencer_tb;
    import home_search_pkg::*;
    localparam int unit_c = 2;
    // enable bits set on purpose: the search must ignore them
    localparam logic [7:0] cfg_v = 8'hAE;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] p;
        logic [4:0] on;
        logic [4:0] off;
        logic [7:0] err;
        logic s1;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, near, home, zph, lim_p, lim_n, odone;
    logic run_o, dir_o, low_o, ofs_o, dcc_pin, clr_o;
    logic [15:0] spd;
    logic [4:0] son = 5'h00;
    logic [4:0] soff = 5'h00;
    logic load = 1'b0;
    logic signed [15:0] start_pos = 16'sh0000;
    logic signed [15:0] pos;
    logic signed [15:0] max_pos;
    int mismatches = 0;
    int num_checks = 0;
    int dcc_cur = 0, dcc_w = 0, dcc_n = 0, clr_n = 0;
    row_t rows [10] = '{
        '{16'h4955, 16'h0000, 5'h00, 5'h00, 8'h00, 1'b1},
        '{16'h0055, 16'h0037, 5'h00, 5'h00, 8'h00, 1'b0},
        '{16'h0010, 16'h0051, 5'h00, 5'h00, 8'h80, 1'b0},
        '{16'h0004, 16'h0000, 5'h02, 5'h00, 8'h04, 1'b0},
        '{16'h0004, 16'h0000, 5'h00, 5'h02, 8'h04, 1'b0},
        '{16'h0010, 16'h0000, 5'h08, 5'h00, 8'h08, 1'b0},
        '{16'h0010, 16'h0000, 5'h00, 5'h04, 8'h08, 1'b0},
        '{16'h0005, 16'h0000, 5'h00, 5'h01, 8'h00, 1'b1},
        '{16'h0210, 16'h0000, 5'h00, 5'h00, 8'h08, 1'b0},
        '{16'h0404, 16'h0000, 5'h00, 5'h00, 8'h00, 1'b0}};
    always #5 pclk = ~pclk;
    home_search_sequencer #(.dcc_unit_cycles(unit_c)) u_dut
    (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .near_home_input(near), .home_input(home), .z_phase_input(zph),
        .limit_pos_input(lim_p), .limit_neg_input(lim_n), .offset_done(odone),
        .drive_run(run_o), .drive_dir_neg(dir_o), .drive_low_speed(low_o),
        .drive_offset(ofs_o), .home_search_speed(spd), .shared_clear_output_pin(dcc_pin),
        .clear_counters(clr_o)
    );
    sensor_model u_sensors
    (
        .pclk(pclk), .presetn(presetn), .drive_run(run_o), .drive_dir_neg(dir_o),
        .drive_offset(ofs_o), .cfg(cfg_v), .stuck_on(son), .stuck_off(soff), .load(load),
        .start_pos(start_pos), .pos(pos), .near_home_input(near), .home_input(home),
        .z_phase_input(zph), .limit_pos_input(lim_p), .limit_neg_input(lim_n),
        .offset_done(odone)
    );
    ////////////////////////////////////////
    // pulse width, pulse counts and furthest forward position
    always @(posedge pclk)
    begin
        dcc_cur <= (dcc_pin === 1'b1) ? dcc_cur + 1 : 0;
        if (dcc_pin !== 1'b1 && dcc_cur != 0)
        begin
            dcc_w <= dcc_cur;
            dcc_n <= dcc_n + 1;
        end
        if (clr_o === 1'b1)
            clr_n <= clr_n + 1;
        if (load)
            max_pos <= start_pos;
        else if (pos > max_pos)
            max_pos <= pos;
    end
    task automatic test_done;
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            mismatches++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
    endtask
    task automatic cmd(input logic [15:0] code, input logic [15:0] d);
        wr(OFS_DATA_LOW, {16'h0000, d});
        wr(OFS_COMMAND, {16'h0000, code});
    endtask
    task automatic arm(input logic [15:0] mode, input logic [15:0] p, input logic [4:0] on,
        input logic [4:0] off);
        @(posedge pclk);
        son <= on;
        soff <= off;
        start_pos <= p;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        clr_n = 0;
        dcc_n = 0;
        cmd(CMD_LOAD_MODE, mode);
        // low speed kept below any initial speed
        cmd(CMD_LOAD_SPEED, 16'h0032);
        @(posedge pclk);
        chk("speed", 32'h0000_0032, 32'(spd));
        wr(OFS_COMMAND, 32'(CMD_START));
    endtask
    // polling is coarse: short states may go unseen
    task automatic finish(output logic [31:0] mask);
        logic [31:0] r;
        int n;
        mask = 32'h0000_0000;
        n = 0;
        do
        begin
            rd(OFS_AXIS_ERROR, r);
            mask[r[12:8]] = 1'b1;
            rd(OFS_MAIN_STATUS, r);
            n++;
        end
        while (r[MS_RUNNING] === 1'b1 && n < 1500);
        chk("search end", 32'h0000_0000, 32'(r[MS_RUNNING]));
    endtask
    initial
    begin
        #900_000;
        mismatches++;
        test_done;
    end
    initial
    begin
        logic [31:0] r;
        logic [31:0] m;
        logic e;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFS_INPUT_CFG, 32'(cfg_v));
        rd(OFS_INPUT_CFG, r);
        chk("input cfg", 32'(cfg_v), r);
        foreach (rows[i])
        begin
            arm(rows[i].mode, rows[i].p, rows[i].on, rows[i].off);
            finish(m);
            rd(OFS_AXIS_ERROR, r);
            chk("error bits", 32'(rows[i].err), r & 32'h0000_008C);
            chk("exec state", 32'(EXEC_IDLE), 32'(r[12:8]));
            rd(OFS_AXIS_STOP, r);
            chk("stop bits", 32'({rows[i].err[3:2], 12'h000}), r & 32'h0000_3000);
            rd(OFS_MAIN_STATUS, r);
            chk("main error", 32'(rows[i].err != 8'h00), 32'(r[MS_ERROR]));
            chk("step1 seen", 32'(rows[i].s1), 32'(m[EXEC_S1]));
            chk("counter clear", 32'(rows[i].mode[8] && rows[i].err == 8'h00), clr_n);
            chk("clear pulses", 32'(rows[i].mode[MODE_DCC_EN]), dcc_n);
            if (rows[i].mode[MODE_DCC_EN])
                chk("clear width", 32'(DCC_MULT[rows[i].mode[15:13]] * unit_c), dcc_w);
            if (rows[i].on[3])
                chk("no advance", 32'(rows[i].p), 32'(max_pos));
            if (rows[i].mode[6] && rows[i].s1)
                chk("steps", 32'h0000_0007, 32'({m[EXEC_S2], m[EXEC_S3], m[EXEC_S4]}));
        end
        arm(16'h0010, 16'h0051, 5'h00, 5'h00);
        finish(m);
        cmd(CMD_CLR_STATUS, 16'h0000);
        rd(OFS_AXIS_ERROR, r);
        chk("z flag cleared", 32'h0000_0000, r & 32'h0000_0080);
        // with no limit and no home the search would run on until stopped
        for (int j = 0; j < 2; j++)
        begin
            arm(16'h0004, 16'h0000, 5'h00, 5'h1A);
            repeat (600) @(posedge pclk);
            rd(OFS_MAIN_STATUS, r);
            chk("runs on", 32'h0000_0001, 32'(r[MS_RUNNING]));
            chk("low speed", 32'h0000_0001, 32'(low_o));
            wr(OFS_COMMAND, j == 0 ? 32'(CMD_DEC_STOP) : 32'(CMD_INST_STOP));
            finish(m);
            rd(OFS_AXIS_ERROR, r);
            chk("stop flags", 32'h0000_0000, r & 32'h0000_008C);
        end
        wr(OFS_MODE, 32'h0000_FFFF);
        rd(OFS_MODE, r);
        chk("mode read only", 32'h0000_0004, r);
        apb(8'h20, 1'b0, 32'h0000_0000, r, e);
        chk("unmapped err", 32'h0000_0001, 32'(e));
        chk("unmapped data", 32'h0000_0000, r);
        arm(16'h0004, 16'h0000, 5'h00, 5'h1A);
        repeat (50) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("reset drive", 32'h0000_0000, 32'({run_o, clr_o, dcc_pin}));
        presetn <= 1'b1;
        rd(OFS_MODE, r);
        chk("reset mode", 32'(MODE_RESET), r);
        rd(OFS_INPUT_CFG, r);
        chk("reset cfg", 32'(CFG_RESET), r);
        rd(OFS_MAIN_STATUS, r);
        chk("reset status", 32'h0000_0000, r);
        test_done;
    end
endmodule
`default_nettype wire
